// [verilog/card_host_pkg.sv]
// Constants shared by the flash card host controller.
// Notes on behaviour
// RULE_01 - CE1 low enables the even byte lane, CE2 low the odd lane.
// RULE_02 - An 8-bit access reaches every byte on the low lane using A0.
// RULE_03 - Word accesses ignore A0 and move a whole 16-bit word.
// RULE_04 - Address pins A0 to A25 give up to 64MB directly.
// RULE_05 - Address bits above the card density's top bit are ignored.
// RULE_06 - Byte read: even byte on low lane when A0 low, odd when high.
// RULE_07 - Word access: odd byte on high lane, even byte on low lane.
// RULE_08 - REG low selects attribute memory, REG high common memory.
// RULE_09 - Attribute memory holds only even bytes; odd data is not valid.
// RULE_10 - Read data is obtained with OE low, WE high, card enabled.
// RULE_11 - Write data transfers with WE low, OE high, card enabled.
// RULE_12 - The card holds ready/busy low while an algorithm runs.
// RULE_13 - The host pulls ready/busy up and reads released high as ready.
// RULE_14 - Card detect pins are grounded; the host pulls up and watches them.
// RULE_15 - WP high means the card blocks all writes internally.
// RULE_16 - A card without the switch holds WP low, protection off.
// RULE_17 - A high level on the reset pin returns the card to defaults.
// RULE_18 - The card never inserts waits; its wait pin stays high.
// RULE_19 - Both battery detect outputs are held high at all times.
// RULE_20 - Both voltage sense outputs are open, meaning a 5V card.
// RULE_21 - With both enables high the card is in standby, bus floating.
// RULE_22 - Bit 7 at attribute address 4000h holds the card in soft reset.
// RULE_23 - Bit 2 at attribute address 4002h powers down all memories.
// RULE_24 - Status at 4100h echoes soft reset in bit 5, power-down in bit 3.
// RULE_25 - Status bit 0 reads 1 when the card is ready.
package card_host_pkg;
   localparam int          ADDR_W          = 26;
   localparam logic [25:0] COR_ADDR        = 26'h0004000;
   localparam logic [25:0] CSR_ADDR        = 26'h0004002;
   localparam logic [25:0] STAT_ADDR       = 26'h0004100;
   localparam int          SOFT_RESET_POS  = 7;
   localparam int          SLEEP_POS       = 2;
   localparam int          ECHO_RESET_POS  = 5;
   localparam int          ECHO_SLEEP_POS  = 3;
   localparam int          READY_POS       = 0;
   localparam int          CLK_NS          = 100;
   localparam int          SETUP_NS        = 100;
   localparam int          STROBE_NS       = 150;
   localparam int          RECOVER_NS      = 20;
   localparam logic [3:0]  SETUP_CYC       = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  STROBE_CYC      = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  RECOVER_CYC     = 4'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} phase_t;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_ODD} size_t;
endpackage

// [verilog/card_host.sv]
// Host-side controller that runs byte and word cycles on a flash card socket.
`timescale 1ns/1ps
module card_host
   import card_host_pkg::*;
#(
   parameter int TOP_BIT = 25
) (
   input  wire logic              i_clock,
   input  wire logic              i_nrst,
   input  wire logic              i_req,
   input  wire logic              i_write,
   input  wire logic              i_attr,
   input  wire logic [1:0]        i_size,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [15:0]       i_wdata,
   output logic                   o_ready,
   output logic                   o_done,
   output logic [15:0]            o_rdata,
   output logic                   o_blocked,
   output logic                   o_card_present,
   output logic                   o_card_ready,
   output logic                   o_protected,
   input  wire logic              i_card_reset,
   output logic                   o_ce1_n,
   output logic                   o_ce2_n,
   output logic                   o_oe_n,
   output logic                   o_we_n,
   output logic                   o_reg_n,
   output logic                   o_rst,
   output logic [ADDR_W-1:0]      o_a,
   input  wire logic [15:0]       i_d,
   output logic [15:0]            o_d,
   output logic                   o_d_lo_oe_n,
   output logic                   o_d_hi_oe_n,
   input  wire logic              i_ready_busy_n,
   input  wire logic              i_wp,
   input  wire logic              i_cd1_n,
   input  wire logic              i_cd2_n
);
   // Whole controller state, registered as one word.
   typedef struct packed {
      phase_t              phase;
      logic [3:0]          cnt;
      logic                wr;
      logic                attr;
      size_t               size;
      logic [ADDR_W-1:0]   a;
      logic [15:0]         wd;
      logic [15:0]         rd;
      logic                done;
      logic                blocked;
      logic [4:0]          s1;
      logic [4:0]          s2;
   } state_t;

   state_t st_ff;
   state_t nxt_st;
   logic   rb_s;
   logic   wp_s;
   logic   present_s;

   // Synchronised pin levels: ready_busy_n, wp, cd1_n, cd2_n, spare top bit tied low.
   assign rb_s      = st_ff.s2[0];
   assign wp_s      = st_ff.s2[1];
   assign present_s = ~st_ff.s2[2] & ~st_ff.s2[3];  // [RULE_14]

   // Clears address bits above the card's top bit.
   function automatic logic [ADDR_W-1:0] trim(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] m;
      m = '0;
      for (int i = 0; i <= TOP_BIT; i++) begin
         m[i] = 1'b1;
      end
      return a & m;  // [RULE_04] [RULE_05]
   endfunction

   // Next state of the cycle sequencer and the pin synchronisers.
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.s1   = {1'b0, i_cd2_n, i_cd1_n, i_wp, i_ready_busy_n};
      nxt_st.s2   = st_ff.s1;
      case (st_ff.phase)
         ST_IDLE: begin
            if (i_req) begin
               nxt_st.wr      = i_write;
               nxt_st.attr    = i_attr;  // [RULE_22] [RULE_23]
               nxt_st.size    = size_t'(i_size);
               nxt_st.a       = trim(i_addr);
               nxt_st.wd      = i_wdata;
               nxt_st.cnt     = SETUP_CYC;
               nxt_st.blocked = i_write & wp_s;  // [RULE_15]
               nxt_st.phase   = ST_SETUP;
               if (size_t'(i_size) == SZ_BYTE && i_addr[0]) begin
                  nxt_st.wd = {8'h00, i_wdata[15:8]};  // [RULE_02]
               end
            end
         end
         ST_SETUP: begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
            if (st_ff.cnt == 4'h1) begin
               nxt_st.cnt   = STROBE_CYC;
               nxt_st.phase = ST_STROBE;
            end
         end
         ST_STROBE: begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
            if (st_ff.cnt == 4'h1) begin
               nxt_st.cnt   = RECOVER_CYC;
               nxt_st.phase = ST_RECOVER;
               if (!st_ff.wr) begin
                  // Read data lands on lanes by access size.
                  case (st_ff.size)
                     SZ_WORD: nxt_st.rd = st_ff.attr ? {8'h00, i_d[7:0]} : i_d;  // [RULE_07] [RULE_09]
                     SZ_ODD:  nxt_st.rd = st_ff.attr ? 16'h0000 : {i_d[15:8], 8'h00};
                     default: nxt_st.rd = (st_ff.attr & st_ff.a[0]) ? 16'h0000
                                                                    : {8'h00, i_d[7:0]};  // [RULE_06]
                  endcase
               end
            end
         end
         default: begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
            if (st_ff.cnt == 4'h1) begin
               nxt_st.phase = ST_IDLE;
               nxt_st.done  = 1'b1;
            end
         end
      endcase
   end

   // Registers the whole state.
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Phase flags that the pin decode below is built from.
   logic active;
   logic strobe;
   assign active = st_ff.phase != ST_IDLE;
   assign strobe = st_ff.phase == ST_STROBE;

   // Card enables: even lane on CE1, odd lane on CE2, A0 steers byte mode.
   assign o_ce1_n = ~(active & st_ff.size != SZ_ODD);       // [RULE_01] [RULE_02]
   assign o_ce2_n = ~(active & st_ff.size != SZ_BYTE);      // [RULE_01] [RULE_21]
   assign o_a     = (st_ff.size == SZ_BYTE) ? st_ff.a : {st_ff.a[ADDR_W-1:1], 1'b0};  // [RULE_03]
   assign o_reg_n = ~(active & st_ff.attr);                  // [RULE_08]
   assign o_oe_n  = ~(strobe & ~st_ff.wr);                   // [RULE_10]
   assign o_we_n  = ~(strobe & st_ff.wr & ~st_ff.blocked);   // [RULE_11]
   assign o_rst   = i_card_reset;                            // [RULE_17]
   assign o_d     = st_ff.wd;
   assign o_d_lo_oe_n = ~(active & st_ff.wr & st_ff.size != SZ_ODD);
   assign o_d_hi_oe_n = ~(active & st_ff.wr & st_ff.size != SZ_BYTE & ~st_ff.attr);  // [RULE_09]
   assign o_ready        = ~active;
   assign o_done         = st_ff.done;
   assign o_rdata        = st_ff.rd;
   assign o_blocked      = st_ff.blocked;
   assign o_card_present = present_s;
   assign o_card_ready   = rb_s;  // [RULE_13] [RULE_12]
   assign o_protected    = wp_s;  // [RULE_16]

   // Socket protocol checks on what the controller drives.
   chk_read_no_drive: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_10]
      !o_oe_n |-> (o_d_lo_oe_n && o_d_hi_oe_n)) else $error("Host drives bus during read.");
   chk_oe_we_excl: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_11]
      !(!o_oe_n && !o_we_n)) else $error("OE and WE both low.");
   chk_idle_standby: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_21]
      o_ready |-> (o_ce1_n && o_ce2_n && o_oe_n && o_we_n)) else $error("Idle not standby.");
   chk_word_a0: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_03]
      (!o_ce1_n && !o_ce2_n) |-> !o_a[0]) else $error("A0 set on word access.");
   chk_protect_block: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_15]
      o_blocked |-> o_we_n) else $error("Write strobe on protected card.");
   chk_strobe_len: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_10]
      $fell(o_oe_n) |-> !o_oe_n[*2] ##1 o_oe_n) else $error("Read strobe length wrong.");
   chk_attr_hi_lane: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_09]
      !o_reg_n |-> o_d_hi_oe_n) else $error("Odd lane driven in attribute space.");
   chk_done_spacing: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_11]
      (i_req && o_ready) |=> ##4 o_done) else $error("Cycle length wrong.");

   // The card never sees an address bit above the density's top bit.
   chk_addr_trim: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_05]
      (!o_ce1_n || !o_ce2_n) |-> ((o_a >> (TOP_BIT + 1)) == '0))
      else $error("Address bit above top bit.");
   // A byte access leaves the odd lane to the card.
   chk_byte_hi_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_02]
      (!o_ce1_n && o_ce2_n) |-> o_d_hi_oe_n)
      else $error("Odd lane driven on byte access.");
   // An odd-only access leaves the even lane alone.
   chk_odd_lo_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_07]
      (o_ce1_n && !o_ce2_n) |-> o_d_lo_oe_n)
      else $error("Even lane driven on odd access.");

   // Write data stands on the even lane while its strobe is low.
   chk_write_lane_drive: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_11]
      (!o_we_n && !o_ce1_n) |-> !o_d_lo_oe_n)
      else $error("Even lane undriven during write.");
   // No strobe is given without a card enable.
   chk_strobe_enabled: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_10]
      (!o_oe_n || !o_we_n) |-> (!o_ce1_n || !o_ce2_n))
      else $error("Strobe without card enable.");
   // The cycle has ended with the card in standby when done pulses.
   chk_done_standby: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_21]
      o_done |-> (o_ready && o_ce1_n && o_ce2_n))
      else $error("Done while card still enabled.");

   // The write strobe lasts exactly two clocks.
   chk_write_len: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_11]
      $fell(o_we_n) |-> !o_we_n[*2] ##1 o_we_n)
      else $error("Write strobe length wrong.");
   // Address and plane hold still under the read strobe.
   chk_read_addr_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_10]
      $fell(o_oe_n) |=> ($stable(o_a) && $stable(o_reg_n)))
      else $error("Address moved during read.");
   // Address and data hold still under the write strobe.
   chk_write_data_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_11]
      $fell(o_we_n) |=> ($stable(o_d) && $stable(o_a)))
      else $error("Data moved during write.");

   // A card enable is set up one clock before the write strobe falls.
   chk_write_setup: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_11]
      $fell(o_we_n) |-> (!$past(o_ce1_n) || !$past(o_ce2_n)))
      else $error("Write strobe without enable setup.");
   // A write taken while protected is marked blocked.
   chk_protect_capture: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_15]
      (i_req && o_ready && i_write && o_protected) |=> o_blocked)
      else $error("Protected write not blocked.");
   // An idle socket selects common memory.
   chk_idle_common: assert property (@(posedge i_clock) disable iff (!i_nrst)  // [RULE_08]
      o_ready |-> o_reg_n)
      else $error("Attribute select while idle.");
endmodule

// [tb/card_model.sv]
// Behavioural flash card as seen from the socket, with data bus resolution.
`timescale 1ns/1ps
module card_model
   import card_host_pkg::*;
#(
   parameter int TOP_BIT = 25
) (
   input  wire logic        i_clock,
   input  wire logic        i_ce1_n,
   input  wire logic        i_ce2_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic        i_reg_n,
   input  wire logic [25:0] i_a,
   input  wire logic [15:0] i_d,
   input  wire logic        i_lo_oe_n,
   input  wire logic        i_hi_oe_n,
   input  wire logic        i_busy,
   input  wire logic        i_wp,
   input  wire logic        i_inserted,
   output logic [15:0]      o_d,
   output logic             o_ready_busy_n,
   output logic             o_wp,
   output logic             o_cd_n
);
   logic [7:0]  mem [int];
   logic [15:0] flt = 16'h6c93;
   logic [15:0] cd;
   logic        rd_on;
   int          ev;
   int          od;
   logic [TOP_BIT:0] ak;
   logic [7:0]  stat;
   logic        soft_reset_bit = 1'b0;
   logic        sleep_request_bit = 1'b0;
   function automatic logic [7:0] rd(int k);
      return mem.exists(k) ? mem[k] : 8'h00;
   endfunction
   // Byte keys drop A0 and every address bit above the card's top bit.
   assign ev = int'({~i_reg_n, i_a[TOP_BIT:1], 1'b0});
   assign od = ev + 1;
   assign ak = {i_a[TOP_BIT:1], 1'b0};
   // Status byte: soft reset and sleep echoes plus the live ready line.
   always_comb begin
      stat = 8'h00;
      stat[ECHO_RESET_POS] = soft_reset_bit;
      stat[ECHO_SLEEP_POS] = sleep_request_bit;
      stat[READY_POS] = !i_busy;
   end
   assign rd_on = !i_oe_n && i_we_n;
   // Attribute odd bytes are junk, lanes nobody drives float to a toggling pattern.
   // Read data answers at once, so the card never asks for a wait state.
   always_comb begin
      cd[7:0] = (i_a[0] && i_ce2_n) ? (i_reg_n ? rd(od) : flt[7:0]) : rd(ev);
      cd[15:8] = i_reg_n ? rd(od) : flt[15:8];
      if (!i_reg_n && ak == STAT_ADDR[TOP_BIT:0]) cd[7:0] = stat;
      o_d[7:0] = !i_lo_oe_n ? i_d[7:0] : (rd_on && !i_ce1_n) ? cd[7:0] : flt[7:0];
      o_d[15:8] = !i_hi_oe_n ? i_d[15:8] : (rd_on && !i_ce2_n) ? cd[15:8] : flt[15:8];
   end
   // Data is taken at each rising clock edge of the write strobe; WP locks the array.
   always @(posedge i_clock) begin
      flt <= ~flt;
      if (!i_we_n && i_oe_n && !i_wp) begin
         if (!i_ce1_n && !(i_a[0] && i_ce2_n)) mem[ev] = o_d[7:0];
         if (!i_ce1_n && i_a[0] && i_ce2_n && i_reg_n) mem[od] = o_d[7:0];
         if (!i_ce2_n && i_reg_n) mem[od] = o_d[15:8];
         if (!i_reg_n && !i_ce1_n && !(i_a[0] && i_ce2_n)) begin
            if (ak == COR_ADDR[TOP_BIT:0]) soft_reset_bit = o_d[SOFT_RESET_POS];
            if (ak == CSR_ADDR[TOP_BIT:0]) sleep_request_bit = o_d[SLEEP_POS];
         end
      end
   end
   // Open-drain ready line and grounded detect pins against the host pull-ups.
   assign o_ready_busy_n = i_busy ? 1'b0 : 1'b1;
   assign o_wp = i_wp;
   assign o_cd_n = !i_inserted;
   // Battery detect and voltage sense reach no host pin here; the host takes
   // the battery as good and the supply as 5V.
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the card host controller against a card model.
`timescale 1ns/1ps
module tb_top;
   import card_host_pkg::*;
   localparam int TB = 21;
   logic        i_clock = 0, i_nrst = 0, i_req = 0, i_write = 0, i_attr = 0, i_card_reset = 0;
   logic        busy = 0, wp = 0, ins = 1, sr = 0, sl = 0;
   logic [1:0]  i_size = 0;
   logic [25:0] i_addr = 0, o_a;
   logic [15:0] i_wdata = 0, o_rdata, o_d, i_d, r;
   logic        o_ready, o_done, o_blocked, o_card_present, o_card_ready, o_protected, o_rst;
   logic        o_ce1_n, o_ce2_n, o_oe_n, o_we_n, o_reg_n, o_d_lo_oe_n, o_d_hi_oe_n;
   logic        i_ready_busy_n, i_wp, i_cd1_n;
   logic [7:0]  mem [int];
   int          err_total = 0, n_checks = 0;
   card_host #(.TOP_BIT(TB)) dut (.i_clock, .i_nrst, .i_req, .i_write, .i_attr, .i_size,
      .i_addr, .i_wdata, .o_ready, .o_done, .o_rdata, .o_blocked, .o_card_present,
      .o_card_ready, .o_protected, .i_card_reset, .o_ce1_n, .o_ce2_n, .o_oe_n, .o_we_n,
      .o_reg_n, .o_rst, .o_a, .i_d, .o_d, .o_d_lo_oe_n, .o_d_hi_oe_n, .i_ready_busy_n,
      .i_wp, .i_cd1_n, .i_cd2_n(i_cd1_n));
   card_model #(.TOP_BIT(TB)) card (.i_clock, .i_ce1_n(o_ce1_n), .i_ce2_n(o_ce2_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_reg_n(o_reg_n), .i_a(o_a), .i_d(o_d),
      .i_lo_oe_n(o_d_lo_oe_n), .i_hi_oe_n(o_d_hi_oe_n), .i_busy(busy), .i_wp(wp),
      .i_inserted(ins), .o_d(i_d), .o_ready_busy_n(i_ready_busy_n), .o_wp(i_wp), .o_cd_n(i_cd1_n));
   // Free-running bench clock.
   always #(CLK_NS / 2) i_clock = ~i_clock;
   function automatic logic [7:0] mb(int k);
      return mem.exists(k) ? mem[k] : 8'h00;
   endfunction
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One transfer, checked against the byte model kept here.
   task automatic op(logic w, logic at, logic [1:0] sz, logic [25:0] a, logic [15:0] wd);
      int n, e, o;
      logic [15:0] g;
      logic [TB:0] ak;
      e = int'({at, a[TB:1], 1'b0});
      ak = {a[TB:1], 1'b0};
      o = e + 1;
      @(negedge i_clock);
      {i_req, i_write, i_attr, i_size, i_addr, i_wdata} = {1'b1, w, at, sz, a, wd};
      @(negedge i_clock);
      i_req = 1'b0;
      for (n = 0; n < 20 && o_done !== 1'b1; n++) @(negedge i_clock);
      chk("latency", 16'(n), 16'(SETUP_CYC + STROBE_CYC + RECOVER_CYC));
      g = {at ? 8'h00 : mb(o), mb(e)};
      if (at && ak == STAT_ADDR[TB:0]) begin
         g[7:0] = 8'h00;
         g[ECHO_RESET_POS] = sr;
         g[ECHO_SLEEP_POS] = sl;
         g[READY_POS] = !busy;
      end
      if (!w) chk("rd_blocked", {15'h0, o_blocked}, 16'h0000);
      if (w) begin
         chk("blocked", {15'h0, o_blocked}, {15'h0, wp});
         if (!wp && sz != 2'd2 && !(sz == 2'd0 && a[0])) begin
            mem[e] = wd[7:0];
            if (at && ak == COR_ADDR[TB:0]) sr = wd[SOFT_RESET_POS];
            if (at && ak == CSR_ADDR[TB:0]) sl = wd[SLEEP_POS];
         end
         if (!wp && !at && (sz != 2'd0 || a[0])) mem[o] = wd[15:8];
      end else if (sz == 2'd0) begin
         chk("byte", o_rdata, {8'h00, a[0] ? g[15:8] : g[7:0]});
      end else if (sz == 2'd1) begin
         chk("word", o_rdata, g);
      end else begin
         chk("odd", o_rdata, {g[15:8], 8'h00});
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Pin status first, then random traffic with high address bits set to be dropped.
   initial begin
      void'($urandom(32'hef7f));
      repeat (2) @(negedge i_clock);
      i_nrst = 1'b1;
      for (int k = 0; k < 8; k++) begin
         {ins, busy, wp, i_card_reset} = 4'($urandom);
         repeat (3) @(negedge i_clock);
         chk("pins", {12'h0, o_card_present, o_card_ready, o_protected, o_rst},
            {12'h0, ins, !busy, wp, i_card_reset});
      end
      for (int k = 0; k < 80; k++) begin
         r = 16'($urandom);
         wp = (r[3:0] == 4'h0);
         repeat (3) @(negedge i_clock);
         op(r[4] | (k < 20), r[5], 2'(r[7:6] % 3), {r[11:8], 19'h0, r[14:12]}, 16'($urandom));
      end
      // Card registers by attribute byte accesses; the status byte echoes them.
      wp = 1'b0;
      for (int k = 0; k < 4; k++) begin
         busy = k[0];
         repeat (3) @(negedge i_clock);
         op(1'b1, 1'b1, 2'd0, COR_ADDR, 16'(k[0]) << SOFT_RESET_POS);
         op(1'b1, 1'b1, 2'd0, CSR_ADDR, 16'(k[1]) << SLEEP_POS);
         op(1'b0, 1'b1, 2'd0, STAT_ADDR, 16'h0000);
      end
      chk("standby", {12'h0, o_ce1_n, o_ce2_n, o_d_lo_oe_n, o_d_hi_oe_n}, 16'h000f);
      conclude();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #(CLK_NS * 5000);
      err_total++;
      conclude();
   end
endmodule
